// File: irq_mask_pkg.sv
/*
  Constants for the interrupt mask and debounce block: register indexes,
  field positions, reset values and timing figures.
  Assumes a 200 MHz APB clock; register indexes are word indexes on APB.
*/
package irq_mask_pkg;

  // ----------------------------------------------------------------
  // Register indexes (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [11:0] IDX_STATUS_ONE   = 12'h730;  // Latched events, group one.
  localparam logic [11:0] IDX_STATUS_TWO   = 12'h731;  // Latched events, group two.
  localparam logic [11:0] IDX_RAW_TWO      = 12'h732;  // Live source levels, group two; the thermal bits show the filtered level.
  localparam logic [11:0] IDX_MASK_ONE     = 12'h738;  // Mask, group one.
  localparam logic [11:0] IDX_MASK_TWO     = 12'h739;  // Mask, group two.
  localparam logic [11:0] IDX_OUT_CTRL     = 12'h740;  // Global output mask.
  localparam logic [11:0] IDX_DEBOUNCE     = 12'h748;  // Thermal debounce enables.
  localparam logic [11:0] IDX_RAW_ONE      = 12'h733;  // Live source levels, group one.

  // ----------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------
  // Implemented event bits of group one: pins 11..8 at 10..7, jack 5, pin 1 at 0.
  localparam logic [15:0] GRP_ONE_BITS     = 16'h07a1;
  // Group two: 15,14,12,11,9,8,7,6,5,1,0.
  localparam logic [15:0] GRP_TWO_BITS     = 16'hdbe3;
  // Group one sources that trigger on both edges (all of them).
  localparam logic [15:0] GRP_ONE_BOTH     = 16'h07a1;
  // Group two both-edge sources: thermal warn, locks, mic, thermal shutdown.
  localparam logic [15:0] GRP_TWO_BOTH     = 16'h81e3;
  localparam int          BIT_THERM_WARN   = 15;
  localparam int          BIT_THERM_SHUT   = 0;
  localparam int          BIT_GLOBAL_MASK  = 0;
  localparam int          BIT_WARN_DB      = 5;
  localparam int          BIT_SHUT_DB      = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_ONE_RESET   = 16'h07ff;  // Masks and reserved bits at 1.
  localparam logic [15:0] MASK_TWO_RESET   = 16'hdbe3;
  localparam logic [15:0] OUT_CTRL_RESET   = 16'h0000;
  localparam logic [15:0] DEBOUNCE_RESET   = 16'h003f;  // Both enables and reserved at 1.
  localparam logic [15:0] OUT_CTRL_BITS    = 16'h0001;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ          = 200;
  localparam int          DEBOUNCE_US      = 10;      // Thermal filter settle time.
  localparam int          DEBOUNCE_CYCLES  = DEBOUNCE_US * CLK_MHZ;

endpackage

// File: level_debounce.sv
/*
  Level debounce filter: the output follows the input only after the input
  has stood steady for a set number of clocks; bypassed when not enabled.
  Assumes the input is synchronous to the clock.
*/
`timescale 1ns/1ps
module level_debounce #(
  parameter int CYCLES = irq_mask_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic enable,
  input  wire logic raw_in,
  output logic      clean_out
);

  localparam int CW = $clog2(CYCLES + 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [CW-1:0] count;  // Cycles the input has differed from the output.
    logic          level;  // Filtered level.
  } db_state_t;

  db_state_t state_q;  // Registered state.
  db_state_t state_d;  // Next state.

  // Filter: a glitch shorter than the window restarts the count.
  always_comb
  begin
    state_d = state_q;
    if (!enable)
    begin
      // Bypass: follow the live level at once.
      state_d.level = raw_in;
      state_d.count = '0;
    end
    else if (raw_in == state_q.level)
    begin
      state_d.count = '0;
    end
    else if (state_q.count >= CW'(CYCLES - 1))
    begin
      state_d.level = raw_in;
      state_d.count = '0;
    end
    else
    begin
      state_d.count = state_q.count + CW'(1);
    end
  end

  // Register the state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign clean_out = state_q.level;

endmodule // level_debounce

// File: interrupt_mask_debounce.sv
/*
  Interrupt mask and debounce block with APB register access: latches
  source edges, filters the thermal sources, masks events and drives one
  level interrupt request.
  Assumes sources are synchronous to pclk and an APB master on the bus.
*/
// Decided for this implementation: register access over APB.
//
// Contract
// - Mask bit one blocks that event
// - Group one mask bit positions
// - Group two mask bit positions
// - All mask bits reset to one; the global output mask resets to zero
// - Global output mask at bit zero
// - Thermal debounce enables, reset enabled
// - Edge latches event, write one clears
// - Raw status follows live source; group two thermal bits read the debounced level instead
`timescale 1ns/1ps
module interrupt_mask_debounce #(
  parameter int DB_CYCLES = irq_mask_pkg::DEBOUNCE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [13:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] src_one,
  input  wire logic [15:0] src_two,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0] prev_one;   // Previous source levels, group one.
    logic [15:0] prev_two;   // Previous filtered levels, group two.
    logic [15:0] stat_one;   // Latched events, group one.
    logic [15:0] stat_two;   // Latched events, group two.
    logic [15:0] mask_one;   // Mask register, group one.
    logic [15:0] mask_two;   // Mask register, group two.
    logic [15:0] out_ctrl;   // Global output mask register.
    logic [15:0] debounce;   // Thermal debounce enable register.
    logic [31:0] rdata;      // Read data to the bus.
    logic        ready;      // Access phase answer.
    logic        err;        // Unmapped address answer.
    logic        irq;        // Interrupt request output.
  } top_state_t;

  top_state_t state_q;  // Registered state.
  top_state_t state_d;  // Next state.

  logic [15:0] live_two;   // Group two levels after thermal filtering.
  logic        warn_clean; // Filtered thermal warning.
  logic        shut_clean; // Filtered thermal shutdown.

  // Decode shared by read and write paths: is this word index mapped.
  function automatic logic is_mapped(input logic [11:0] idx);
    return idx == irq_mask_pkg::IDX_STATUS_ONE || idx == irq_mask_pkg::IDX_STATUS_TWO ||
           idx == irq_mask_pkg::IDX_RAW_ONE    || idx == irq_mask_pkg::IDX_RAW_TWO    ||
           idx == irq_mask_pkg::IDX_MASK_ONE   || idx == irq_mask_pkg::IDX_MASK_TWO   ||
           idx == irq_mask_pkg::IDX_OUT_CTRL   || idx == irq_mask_pkg::IDX_DEBOUNCE;
  endfunction

  // Edges that set a latch: rising only, or both edges where allowed.
  function automatic logic [15:0] edge_hits(input logic [15:0] now, input logic [15:0] was,
                                            input logic [15:0] both, input logic [15:0] used);
    return ((now & ~was) | (both & ~now & was)) & used;
  endfunction

  // ----------------------------------------------------------------
  // Thermal filters
  // ----------------------------------------------------------------
  // debounce selects filter
  level_debounce #(.CYCLES(DB_CYCLES)) u_warn_db (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (state_q.debounce[irq_mask_pkg::BIT_WARN_DB]),
    .raw_in    (src_two[irq_mask_pkg::BIT_THERM_WARN]),
    .clean_out (warn_clean)
  );

  level_debounce #(.CYCLES(DB_CYCLES)) u_shut_db (
    .pclk      (pclk),
    .presetn   (presetn),
    .enable    (state_q.debounce[irq_mask_pkg::BIT_SHUT_DB]),
    .raw_in    (src_two[irq_mask_pkg::BIT_THERM_SHUT]),
    .clean_out (shut_clean)
  );

  // Substitute the filtered thermal levels into group two.
  always_comb
  begin
    live_two = src_two & irq_mask_pkg::GRP_TWO_BITS;
    live_two[irq_mask_pkg::BIT_THERM_WARN] = warn_clean;
    live_two[irq_mask_pkg::BIT_THERM_SHUT] = shut_clean;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Bus access, event latching and request generation in one place so the
  // set-over-clear ordering is explicit.
  always_comb
  begin
    logic [11:0] idx;
    logic        acc;
    logic        wr;
    logic [15:0] wd;
    logic [15:0] clr_one;
    logic [15:0] clr_two;
    logic [15:0] pend;
    idx     = paddr[13:2];
    acc     = psel && penable && !state_q.ready;
    wr      = acc && pwrite && is_mapped(idx);
    wd      = pwdata[15:0];
    clr_one = '0;
    clr_two = '0;
    state_d = state_q;
    state_d.ready = acc;
    state_d.err   = acc && !is_mapped(idx);
    state_d.rdata = '0;
    state_d.prev_one = src_one & irq_mask_pkg::GRP_ONE_BITS;
    state_d.prev_two = live_two;

    // Register writes; the mask and debounce registers keep only the bits set in their reset values, the output control only bit 0; all other bits are dropped.
    if (wr)
    begin
      unique case (idx)
        irq_mask_pkg::IDX_STATUS_ONE: clr_one = wd;
        irq_mask_pkg::IDX_STATUS_TWO: clr_two = wd;
        irq_mask_pkg::IDX_MASK_ONE:   state_d.mask_one = wd & irq_mask_pkg::MASK_ONE_RESET;
        irq_mask_pkg::IDX_MASK_TWO:   state_d.mask_two = wd & irq_mask_pkg::MASK_TWO_RESET;
        irq_mask_pkg::IDX_OUT_CTRL:   state_d.out_ctrl = wd & irq_mask_pkg::OUT_CTRL_BITS;
        irq_mask_pkg::IDX_DEBOUNCE:   state_d.debounce = wd & irq_mask_pkg::DEBOUNCE_RESET;
        default:                      state_d.rdata = '0;
      endcase
    end

    // Register reads; unmapped reads return zero with an error.
    if (acc && !pwrite)
    begin
      unique case (idx)
        irq_mask_pkg::IDX_STATUS_ONE: state_d.rdata = {16'h0000, state_q.stat_one};
        irq_mask_pkg::IDX_STATUS_TWO: state_d.rdata = {16'h0000, state_q.stat_two};
        irq_mask_pkg::IDX_RAW_ONE:    state_d.rdata = {16'h0000, state_q.prev_one};
        irq_mask_pkg::IDX_RAW_TWO:    state_d.rdata = {16'h0000, state_q.prev_two};
        irq_mask_pkg::IDX_MASK_ONE:   state_d.rdata = {16'h0000, state_q.mask_one};
        irq_mask_pkg::IDX_MASK_TWO:   state_d.rdata = {16'h0000, state_q.mask_two};
        irq_mask_pkg::IDX_OUT_CTRL:   state_d.rdata = {16'h0000, state_q.out_ctrl};
        irq_mask_pkg::IDX_DEBOUNCE:   state_d.rdata = {16'h0000, state_q.debounce};
        default:                      state_d.rdata = '0;
      endcase
    end

    // edge sets, set wins over clear
    state_d.stat_one = (state_q.stat_one & ~clr_one) |
                       edge_hits(src_one, state_q.prev_one, irq_mask_pkg::GRP_ONE_BOTH,
                                 irq_mask_pkg::GRP_ONE_BITS);
    state_d.stat_two = (state_q.stat_two & ~clr_two) |
                       edge_hits(live_two, state_q.prev_two, irq_mask_pkg::GRP_TWO_BOTH,
                                 irq_mask_pkg::GRP_TWO_BITS);

    pend = (state_q.stat_one & ~state_q.mask_one & irq_mask_pkg::GRP_ONE_BITS) |
           (state_q.stat_two & ~state_q.mask_two & irq_mask_pkg::GRP_TWO_BITS);
    state_d.irq = (|pend) && !state_q.out_ctrl[irq_mask_pkg::BIT_GLOBAL_MASK];
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Reset values put every source under mask until software opens it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q          <= '0;
      state_q.mask_one <= irq_mask_pkg::MASK_ONE_RESET;
      state_q.mask_two <= irq_mask_pkg::MASK_TWO_RESET;
      state_q.out_ctrl <= irq_mask_pkg::OUT_CTRL_RESET;
      state_q.debounce <= irq_mask_pkg::DEBOUNCE_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata  = state_q.rdata;
  assign pready  = state_q.ready;
  assign pslverr = state_q.err;
  assign irq     = state_q.irq;

endmodule // interrupt_mask_debounce

// File: irq_mask_sva.sv
/*
  Port-level checks for the interrupt mask block.
  Assumes one pclk domain and an APB master that keeps the protocol.
*/
`timescale 1ns/1ps
module irq_mask_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] src_one,
  input wire logic [15:0] src_two,
  input wire logic        irq
);
  // ------------------------------------------------------------
  // Shadow of software state
  // ------------------------------------------------------------
  logic [11:0] idx;        // Word index of the access.
  logic        done;       // A transfer completes at this edge.
  logic        mapped;     // The index names a register.
  logic        gmask_q;    // Shadow of the global output mask.
  logic        touched_q;  // A mask register has been written.
  assign idx    = paddr[13:2];
  assign done   = psel && penable && pready;
  assign mapped = idx inside {irq_mask_pkg::IDX_STATUS_ONE, irq_mask_pkg::IDX_STATUS_TWO,
                              irq_mask_pkg::IDX_RAW_ONE, irq_mask_pkg::IDX_RAW_TWO,
                              irq_mask_pkg::IDX_MASK_ONE, irq_mask_pkg::IDX_MASK_TWO,
                              irq_mask_pkg::IDX_OUT_CTRL, irq_mask_pkg::IDX_DEBOUNCE};
  // Updated only at completed writes, one edge after the slave itself stores the value.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gmask_q   <= 1'b0;
      touched_q <= 1'b0;
    end
    else if (done && pwrite)
    begin
      gmask_q   <= (idx == irq_mask_pkg::IDX_OUT_CTRL) ? pwdata[0] : gmask_q;
      touched_q <= touched_q || idx == irq_mask_pkg::IDX_MASK_ONE || idx == irq_mask_pkg::IDX_MASK_TWO;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_RESET_MASKED: assert property (!touched_q |-> !irq)
    else $error("request raised before any mask was cleared");
  AST_GLOBAL_MASK: assert property (gmask_q && $past(gmask_q, 2) |-> !irq)
    else $error("request high while global mask set");
  AST_CTRL_READBACK: assert property (done && !pwrite && idx == irq_mask_pkg::IDX_OUT_CTRL
    |-> prdata == {31'h0, gmask_q}) else $error("control readback wrong");
  AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
    else $error("ready not one cycle after access");
  AST_READY_PLACE: assert property (pready |-> psel && penable && $past(psel && penable))
    else $error("ready outside second access cycle");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_UNMAPPED: assert property (done |-> pslverr == !mapped)
    else $error("error flag disagrees with address map");
  AST_ERR_READ_ZERO: assert property (done && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read data not zero");
  AST_UPPER_ZERO: assert property (done && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read data not zero");
endmodule // irq_mask_sva

bind interrupt_mask_debounce irq_mask_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .src_one(src_one), .src_two(src_two), .irq(irq));

// File: irq_host_model.sv
/*
  Host side of the request line: counts rising request edges.
  Assumes the request is a level synchronous to pclk.
*/
`timescale 1ns/1ps
module irq_host_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       irq,
  output logic      [7:0] rises
);
  logic irq_q;  // Level at the previous edge.
  // An edge-sensitive host input would see each of these as one service call.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_q <= 1'b0;
      rises <= 8'h00;
    end
    else
    begin
      irq_q <= irq;
      rises <= rises + {7'h0, irq && !irq_q};
    end
  end
endmodule // irq_host_model

// File: interrupt_mask_debounce_tb.sv
/*
  Self-checking bench for the interrupt mask block over APB.
  Assumes the debounce count is shortened to DB cycles.
*/
`timescale 1ns/1ps
module interrupt_mask_debounce_tb;
  localparam int          DB   = 4;  // Short filter count for simulation.
  localparam logic [13:0] A_S1 = {irq_mask_pkg::IDX_STATUS_ONE, 2'b00};
  localparam logic [13:0] A_S2 = {irq_mask_pkg::IDX_STATUS_TWO, 2'b00};
  localparam logic [13:0] A_R1 = {irq_mask_pkg::IDX_RAW_ONE, 2'b00};
  localparam logic [13:0] A_R2 = {irq_mask_pkg::IDX_RAW_TWO, 2'b00};
  localparam logic [13:0] A_M1 = {irq_mask_pkg::IDX_MASK_ONE, 2'b00};
  localparam logic [13:0] A_M2 = {irq_mask_pkg::IDX_MASK_TWO, 2'b00};
  localparam logic [13:0] A_C  = {irq_mask_pkg::IDX_OUT_CTRL, 2'b00};
  localparam logic [13:0] A_D  = {irq_mask_pkg::IDX_DEBOUNCE, 2'b00};
  logic        pclk = 1'b0;  // Bench clock, driven only by the clock process.
  logic        presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [15:0] src_one, src_two;
  logic [7:0]  rises;
  int          bad_count, checked;
  interrupt_mask_debounce #(.DB_CYCLES(DB)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .src_one(src_one), .src_two(src_two), .irq(irq));
  irq_host_model host (.pclk(pclk), .presetn(presetn), .irq(irq), .rises(rises));
  always #2.5 pclk = ~pclk;
  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask
  // One APB transfer; waits for ready with no assumed latency.
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [13:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp, "read data");
    chk({31'h0, rerr}, 32'h0, "mapped read error flag");
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    rd(A_M1, 32'h000007ff);
    rd(A_M2, 32'h0000dbe3);
    rd(A_C, 32'h00000000);
    rd(A_D, 32'h0000003f);
    chk({31'h0, irq}, 32'h0, "request after reset");
    apb(1'b1, 14'h0008, 32'hffffffff);
    chk({31'h0, rerr}, 32'h1, "unmapped write flag");
    apb(1'b0, 14'h0004, 32'h0);
    chk(rdat, 32'h0, "unmapped read data");
    chk({31'h0, rerr}, 32'h1, "unmapped read flag");
    $display("reset test done");
  endtask
  // Raise one source, unmask it, clear it, then drop it and watch the edge kind.
  task automatic t_event(input int g, input int b);
    logic [15:0] rst, both, one;
    rst  = g ? 16'hdbe3 : 16'h07ff;
    both = g ? irq_mask_pkg::GRP_TWO_BOTH : irq_mask_pkg::GRP_ONE_BOTH;
    one  = 16'h0001 << b;
    src_one <= src_one | (g ? 16'h0 : one);
    src_two <= src_two | (g ? one : 16'h0);
    waitc(20);
    rd(g ? A_R2 : A_R1, {16'h0, one});
    chk({31'h0, irq}, 32'h0, "masked event");
    wr(g ? A_M2 : A_M1, {16'h0, rst & ~one});
    waitc(5);
    chk({31'h0, irq}, 32'h1, "unmasked event");
    rd(g ? A_S2 : A_S1, {16'h0, one});
    wr(g ? A_S2 : A_S1, {16'h0, one});
    waitc(5);
    chk({31'h0, irq}, 32'h0, "cleared event");
    src_one <= src_one & ~one;
    src_two <= src_two & ~one;
    waitc(20);
    rd(g ? A_S2 : A_S1, {16'h0, both & one});
    wr(g ? A_S2 : A_S1, {16'h0, one});
    wr(g ? A_M2 : A_M1, {16'h0, rst});
    $display("event test %0d.%0d done", g, b);
  endtask
  task automatic t_global();
    wr(A_M1, 32'h000007fe);
    src_one <= 16'h0001;
    waitc(5);
    chk({31'h0, irq}, 32'h1, "pending request");
    wr(A_C, 32'h00000001);
    waitc(5);
    chk({31'h0, irq}, 32'h0, "global mask on");
    rd(A_C, 32'h00000001);
    wr(A_C, 32'h00000000);
    waitc(5);
    chk({31'h0, irq}, 32'h1, "global mask off");
    src_one <= 16'h0000;
    waitc(5);
    wr(A_S1, 32'h00000001);
    wr(A_M1, 32'h000007ff);
    waitc(5);
    chk({31'h0, irq}, 32'h0, "request gone");
    $display("global mask test done");
  endtask
  // A pulse shorter than DB is filtered only while the enable is set.
  task automatic t_debounce();
    src_two <= 16'h0001;
    waitc(DB - 2);
    src_two <= 16'h0000;
    waitc(20);
    rd(A_S2, 32'h00000000);
    wr(A_D, 32'h0000003e);
    src_two <= 16'h0001;
    waitc(DB - 2);
    src_two <= 16'h0000;
    waitc(20);
    rd(A_S2, 32'h00000001);
    wr(A_S2, 32'h00000001);
    wr(A_D, 32'h0000003f);
    $display("debounce test done");
  endtask
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence. Each event test raises the line once when unmasked, and a
  // both-edge source raises it again on its falling edge while still unmasked;
  // the global test raises it twice. The debounce test keeps every mask set.
  initial
  begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {src_one, src_two, bad_count, checked} = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    for (int i = 0; i < 16; i++)
    begin
      if (irq_mask_pkg::GRP_ONE_BITS[i])
        t_event(0, i);
      if (irq_mask_pkg::GRP_TWO_BITS[i])
        t_event(1, i);
    end
    t_global();
    t_debounce();
    chk({24'h0, rises}, 32'($countones(irq_mask_pkg::GRP_ONE_BITS) + $countones(irq_mask_pkg::GRP_ONE_BOTH) +
        $countones(irq_mask_pkg::GRP_TWO_BITS) + $countones(irq_mask_pkg::GRP_TWO_BOTH) + 2),
        "host request edges");
    wrap_up();
  end
  // Watchdog set well above the roughly 1500 cycles the tests need.
  initial
  begin
    #200000;
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // interrupt_mask_debounce_tb
